// ---- logic/irq_ctrl_pkg.sv ----
// Constants, register indices and source table for the prioritized interrupt controller.
package irq_ctrl_pkg;
  localparam int          NUM_BITS   = 24;
  localparam int          NUM_SRC    = 12;
  localparam logic [9:0]  IDX_POSTED0 = 10'h0DA;
  localparam logic [9:0]  IDX_POSTED1 = 10'h0DB;
  localparam logic [9:0]  IDX_POSTED2 = 10'h0DC;
  localparam logic [9:0]  IDX_SOFTPOST = 10'h0DE;
  localparam logic [9:0]  IDX_MASK2  = 10'h0DF;
  localparam logic [9:0]  IDX_MASK0  = 10'h0E0;
  localparam logic [9:0]  IDX_MASK1  = 10'h0E1;
  localparam logic [9:0]  IDX_VECTOR = 10'h0E2;
  localparam logic [23:0] IMPL_MASK  = 24'h16_60FD;
  localparam logic [23:0] FLAGS_RESET = 24'h00_0000;
  localparam logic [23:0] MASK_RESET = 24'h00_0000;
  localparam int          SOFT_POST_BIT = 7;
  localparam int          GIE_BIT    = 0;
  // Bit index into the flat 24-bit flag space, listed from highest to lowest priority.
  localparam logic [4:0]  SRC_BIT [NUM_SRC] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h07, 5'h05,
                                                5'h0D, 5'h0E, 5'h11, 5'h12, 5'h14, 5'h06};
  localparam logic [7:0]  SRC_VEC [NUM_SRC] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                                                8'h34, 8'h38, 8'h44, 8'h48, 8'h50, 8'h64};
  localparam logic [3:0]  DISPATCH_LAST = 4'hC;
  localparam logic [3:0]  STEP_PUSH_PCH = 4'h0;
  localparam logic [3:0]  STEP_PUSH_PCL = 4'h1;
  localparam logic [3:0]  STEP_PUSH_FLG = 4'h2;
  localparam logic [3:0]  STEP_CLR_FLG  = 4'h3;
  localparam logic [3:0]  STEP_LOAD_PC  = 4'h4;
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b01,
    ST_DISPATCH = 2'b10
  } disp_state_e;
endpackage : irq_ctrl_pkg

// ---- logic/irq_ctrl.sv ----
// Prioritized interrupt controller with APB registers and CPU dispatch sequencer.
//
// The APB interface to the registers is this design's own decision.
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [23:0] srcEvent,
  input  wire logic [7:0]  cpuFlags,
  input  wire logic [15:0] programCounter,
  input  wire logic        instrDone,
  output logic             irqRequest,
  output logic             dispatchBusy,
  output logic             stackPush,
  output logic      [7:0]  stackData,
  output logic             flagsClear,
  output logic             pcLoad,
  output logic      [15:0] pcLoadValue
);

  logic [23:0]  posted_q;
  logic [23:0]  posted_d;
  logic [23:0]  mask_q;
  logic         softPost_q;
  logic [31:0]  prdata_q;
  logic         pslverr_q;
  logic [23:0]  pending;
  logic [7:0]   winVec;
  logic [4:0]   winBit;
  logic         winValid;
  logic         irqActive;
  logic         dispatchStart;
  disp_state_e  state_q;
  logic [3:0]   step_q;
  logic [7:0]   vecSave_q;
  logic [15:0]  pcSave_q;
  logic [7:0]   flagSave_q;
  logic         stackPush_q;
  logic [7:0]   stackData_q;
  logic         flagsClear_q;
  logic         pcLoad_q;
  logic [15:0]  pcLoadValue_q;
  logic [9:0]   regIdx;
  logic         addrAligned;
  logic         regWrite;
  logic         setupRead;
  logic [23:0]  flagLanes;
  logic [23:0]  maskLanes;
  logic [23:0]  wdata24;
  logic [23:0]  swClear;
  logic [23:0]  swSet;
  logic [23:0]  takenClear;
  logic [23:0]  vectorClear;
  logic [23:0]  allClear;
  logic         vectorWrite;
  logic         mapped;
  logic [7:0]   readByte;

  assign regIdx      = paddr[11:2];
  assign addrAligned = (paddr[1:0] == 2'b00);
  assign regWrite    = psel && penable && pwrite && mapped;
  assign setupRead   = psel && !penable;
  assign wdata24     = {3{pwdata[7:0]}};
  assign pready      = 1'b1;
  assign prdata      = prdata_q;
  assign pslverr     = pslverr_q;

  always_comb begin
    mapped    = addrAligned;
    flagLanes = 24'h00_0000;
    maskLanes = 24'h00_0000;
    readByte  = 8'h00;
    unique case (regIdx)
      IDX_POSTED0: begin
        flagLanes = 24'h00_00FF;
        readByte  = posted_q[7:0];
      end
      IDX_POSTED1: begin
        flagLanes = 24'h00_FF00;
        readByte  = posted_q[15:8];
      end
      IDX_POSTED2: begin
        flagLanes = 24'hFF_0000;
        readByte  = posted_q[23:16];
      end
      IDX_SOFTPOST: begin
        readByte = {softPost_q, 7'h00};
      end
      IDX_MASK0: begin
        maskLanes = 24'h00_00FF;
        readByte  = mask_q[7:0];
      end
      IDX_MASK1: begin
        maskLanes = 24'h00_FF00;
        readByte  = mask_q[15:8];
      end
      IDX_MASK2: begin
        maskLanes = 24'hFF_0000;
        readByte  = mask_q[23:16];
      end
      IDX_VECTOR: begin
        readByte = winVec;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign vectorWrite = regWrite && (regIdx == IDX_VECTOR);

  // Only the documented bit positions exist; reserved bits stay zero and read as zero.
  assign pending = posted_q & mask_q & IMPL_MASK;

  // Scan from lowest priority upward so the highest priority left standing wins.
  always_comb begin
    winVec   = 8'h00;
    winBit   = 5'h00;
    winValid = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[SRC_BIT[i]]) begin
        winVec   = SRC_VEC[i];
        winBit   = SRC_BIT[i];
        winValid = 1'b1;
      end
    end
  end

  // Recomputed every cycle, so an unmask or a rising global enable takes effect at once.
  assign irqActive     = winValid && cpuFlags[GIE_BIT];
  assign irqRequest    = irqActive;
  assign dispatchStart = (state_q == ST_IDLE) && instrDone && irqActive;

  always_comb begin
    swClear     = 24'h00_0000;
    swSet       = 24'h00_0000;
    takenClear  = 24'h00_0000;
    vectorClear = 24'h00_0000;
    if (regWrite && !softPost_q) begin
      swClear = flagLanes & ~wdata24;
    end
    if (regWrite && softPost_q) begin
      swSet = flagLanes & wdata24;
    end
    if (dispatchStart) begin
      takenClear[winBit] = 1'b1;
    end
    if (vectorWrite) begin
      vectorClear = pending;
    end
  end

  assign allClear = swClear | takenClear | vectorClear;
  // A hardware event in the same cycle as any clear keeps its flag; nothing is lost.
  assign posted_d = ((posted_q & ~allClear) | srcEvent | swSet) & IMPL_MASK;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      posted_q <= FLAGS_RESET;
    end else begin
      posted_q <= posted_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= MASK_RESET;
    end else if (regWrite) begin
      mask_q <= ((mask_q & ~maskLanes) | (wdata24 & maskLanes)) & IMPL_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      softPost_q <= 1'b0;
    end else if (regWrite && (regIdx == IDX_SOFTPOST)) begin
      softPost_q <= pwdata[SOFT_POST_BIT];
    end
  end

  // Read data is captured in the setup cycle, so the slave never needs a wait state.
  // A refused access returns zero, so a misaligned address never shows a neighbour's contents.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setupRead) begin
      prdata_q  <= {24'h00_0000, (mapped ? readByte : 8'h00)};
      pslverr_q <= !mapped;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      step_q  <= 4'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          step_q <= 4'h0;
          if (dispatchStart) begin
            state_q <= ST_DISPATCH;
          end
        end
        ST_DISPATCH: begin
          step_q <= step_q + 4'h1;
          if (step_q == DISPATCH_LAST) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign dispatchBusy = (state_q == ST_DISPATCH);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vecSave_q  <= 8'h00;
      pcSave_q   <= 16'h0000;
      flagSave_q <= 8'h00;
    end else if (dispatchStart) begin
      vecSave_q  <= winVec;
      pcSave_q   <= programCounter;
      flagSave_q <= cpuFlags;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stackPush_q   <= 1'b0;
      stackData_q   <= 8'h00;
      flagsClear_q  <= 1'b0;
      pcLoad_q      <= 1'b0;
      pcLoadValue_q <= 16'h0000;
    end else begin
      stackPush_q  <= dispatchBusy && (step_q <= STEP_PUSH_FLG);
      flagsClear_q <= dispatchBusy && (step_q == STEP_CLR_FLG);
      pcLoad_q     <= dispatchBusy && (step_q == STEP_LOAD_PC);
      if (dispatchBusy && (step_q == STEP_PUSH_PCH)) begin
        stackData_q <= pcSave_q[15:8];
      end else if (dispatchBusy && (step_q == STEP_PUSH_PCL)) begin
        stackData_q <= pcSave_q[7:0];
      end else if (dispatchBusy && (step_q == STEP_PUSH_FLG)) begin
        stackData_q <= flagSave_q;
      end
      if (dispatchBusy && (step_q == STEP_LOAD_PC)) begin
        pcLoadValue_q <= {8'h00, vecSave_q};
      end
    end
  end

  assign stackPush   = stackPush_q;
  assign stackData   = stackData_q;
  assign flagsClear  = flagsClear_q;
  assign pcLoad      = pcLoad_q;
  assign pcLoadValue = pcLoadValue_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence pushThree_s;
    stackPush ##1 stackPush ##1 stackPush;
  endsequence

  sequence clearThenLoad_s;
    (!stackPush && flagsClear) ##1 (pcLoad && !flagsClear);
  endsequence

  // The flag byte is the third push, so it trails the rise of busy by three cycles.
  sequence flagPush_s;
    ##3 (stackPush && stackData == $past(cpuFlags, 4));
  endsequence

  sequence strobesQuiet_s;
    !stackPush && !flagsClear && !pcLoad;
  endsequence

  dispatch_len_a: assert property ($rose(dispatchBusy) |->
    dispatchBusy[*8] ##1 dispatchBusy[*5] ##1 !dispatchBusy)
    else $error("Dispatch did not last thirteen cycles.");

  push_order_a: assert property ($rose(dispatchBusy) |=> pushThree_s ##1 clearThenLoad_s)
    else $error("Dispatch strobes out of order.");

  push_data_a: assert property ($rose(dispatchBusy) |=>
    stackData == pcSave_q[15:8] ##1 stackData == pcSave_q[7:0])
    else $error("Pushed program counter bytes wrong.");

  push_flags_a: assert property ($rose(dispatchBusy) |-> flagPush_s)
    else $error("Pushed flag byte wrong.");

  idle_quiet_a: assert property (!dispatchBusy |=> strobesQuiet_s)
    else $error("Dispatch strobe outside a dispatch.");

  pc_load_a: assert property ($rose(dispatchBusy) |->
    ##5 (pcLoad && pcLoadValue == {8'h00, $past(winVec, 6)}))
    else $error("Loaded program counter is not the winning vector.");

  pc_high_a: assert property (pcLoad |-> pcLoadValue[15:8] == 8'h00)
    else $error("Upper program counter byte not zero.");

  request_gate_a: assert property (irqRequest |-> (|(posted_q & mask_q)) && cpuFlags[GIE_BIT])
    else $error("Request without pending source or global enable.");

  enable_gate_a: assert property (!cpuFlags[GIE_BIT] |-> !dispatchStart)
    else $error("Dispatch started with global enable clear.");

  enable_rise_a: assert property ($rose(cpuFlags[GIE_BIT]) && winValid |-> irqRequest)
    else $error("Rising global enable did not raise a request.");

  boundary_a: assert property (dispatchStart |-> instrDone && !dispatchBusy)
    else $error("Dispatch began inside an instruction or a dispatch.");

  masked_idle_a: assert property (!(|(posted_q & mask_q)) |-> !winValid)
    else $error("Encoder chose a source that is not pending.");

  mask_keep_a: assert property (regWrite && (|maskLanes) && !dispatchStart |=>
    (posted_q & $past(posted_q)) == $past(posted_q))
    else $error("Mask write dropped a posted flag.");

  taken_clear_a: assert property (dispatchStart && !srcEvent[winBit] && !swSet[winBit] |=>
    !posted_q[$past(winBit)])
    else $error("Taken interrupt stayed posted.");

  event_post_a: assert property (|(srcEvent & IMPL_MASK) |=>
    (posted_q & $past(srcEvent & IMPL_MASK)) == $past(srcEvent & IMPL_MASK))
    else $error("Source event did not post its flag.");

  post_hold_a: assert property (1'b1 |=>
    (posted_q & $past(posted_q & ~allClear)) == $past(posted_q & ~allClear))
    else $error("Posted flag dropped without a clear.");

  sw_clear_a: assert property (regWrite && regIdx == IDX_POSTED0 && !softPost_q &&
    !pwdata[0] && !srcEvent[0] |=> !posted_q[0])
    else $error("Writing zero did not clear the flag.");

  ones_ignored_a: assert property (regWrite && regIdx == IDX_POSTED2 && !softPost_q &&
    pwdata[1] && !posted_q[17] && !srcEvent[17] |=> !posted_q[17])
    else $error("Writing one changed a flag with soft-post off.");

  sw_post_a: assert property (regWrite && regIdx == IDX_POSTED0 && softPost_q &&
    pwdata[0] |=> posted_q[0])
    else $error("Writing one did not post the flag.");

  zero_ignored_a: assert property (regWrite && regIdx == IDX_POSTED0 && softPost_q &&
    !pwdata[0] && posted_q[0] && !dispatchStart |=> posted_q[0])
    else $error("Writing zero cleared a flag with soft-post on.");

  vector_clear_a: assert property (vectorWrite |=>
    (posted_q & $past(pending & ~srcEvent)) == 24'h00_0000)
    else $error("Vector write left a pending flag.");

  vector_read_a: assert property (setupRead && mapped && regIdx == IDX_VECTOR |=>
    prdata[7:0] == $past(winVec))
    else $error("Vector read returned wrong value.");

endmodule : irq_ctrl

// ---- dv/cpu_model.sv ----
// CPU core model that steps one instruction per cycle and takes vectored dispatches.
module cpu_model (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        dispatchBusy,
  input  wire logic        stackPush,
  input  wire logic [7:0]  stackData,
  input  wire logic        flagsClear,
  input  wire logic        pcLoad,
  input  wire logic [15:0] pcLoadValue,
  input  wire logic        flagsSet,
  input  wire logic [7:0]  flagsVal,
  input  wire logic        retIrq,
  output logic             instrDone,
  output logic      [7:0]  cpuFlags,
  output logic      [15:0] programCounter,
  output logic      [23:0] pushLog
);
  timeunit 1ns;
  timeprecision 1ps;
  // The program counter moves only on a vector load or a return, so pushed bytes are predictable.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      instrDone      <= 1'b0;
      cpuFlags       <= 8'h00;
      programCounter <= 16'h1234;
      pushLog        <= 24'h00_0000;
    end else begin
      instrDone <= !dispatchBusy;
      if (stackPush)
        pushLog <= {pushLog[15:0], stackData};
      if (flagsClear)
        cpuFlags <= 8'h00;
      else if (flagsSet)
        cpuFlags <= flagsVal;
      else if (retIrq)
        cpuFlags <= pushLog[7:0];
      if (pcLoad)
        programCounter <= pcLoadValue;
      else if (retIrq)
        programCounter <= pushLog[23:8];
    end
  end
endmodule : cpu_model

// ---- dv/irq_ctrl_tb.sv ----
// Self-checking testbench for the interrupt controller over APB and CPU dispatch.
module irq_ctrl_tb
  import irq_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic        instrDone, irqRequest, dispatchBusy, stackPush, flagsClear, pcLoad, flagsSet, retIrq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] srcEvent, pushLog;
  logic [7:0]  cpuFlags, stackData, flagsVal, r;
  logic [15:0] programCounter, pcLoadValue;
  int          err_count, check_count, busyCnt, loadCnt;
  localparam logic [9:0] POS [3] = '{IDX_POSTED0, IDX_POSTED1, IDX_POSTED2};
  localparam logic [9:0] MSK [3] = '{IDX_MASK0, IDX_MASK1, IDX_MASK2};

  irq_ctrl uut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .srcEvent(srcEvent), .cpuFlags(cpuFlags), .programCounter(programCounter),
    .instrDone(instrDone), .irqRequest(irqRequest), .dispatchBusy(dispatchBusy),
    .stackPush(stackPush), .stackData(stackData), .flagsClear(flagsClear), .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue));
  cpu_model cpu (.core_clk(core_clk), .resetn(resetn), .dispatchBusy(dispatchBusy),
    .stackPush(stackPush), .stackData(stackData), .flagsClear(flagsClear), .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue), .flagsSet(flagsSet), .flagsVal(flagsVal), .retIrq(retIrq),
    .instrDone(instrDone), .cpuFlags(cpuFlags), .programCounter(programCounter),
    .pushLog(pushLog));

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (dispatchBusy === 1'b1)
      busyCnt++;
    if (pcLoad === 1'b1)
      loadCnt++;
  end

  task automatic end_sim();
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // Request stays frozen until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input string n, input logic [9:0] i, input logic [7:0] x);
    apb(1'b0, i, 8'h00);
    chk(n, {24'h00_0000, r}, {24'h00_0000, x});
  endtask : rd

  task automatic ev(input logic [23:0] b);
    @(posedge core_clk);
    srcEvent <= b;
    @(posedge core_clk);
    srcEvent <= 24'h00_0000;
  endtask : ev

  initial begin
    #100us;
    err_count++;
    end_sim();
  end

  initial begin
    core_clk = 1'b0;
    resetn   = 1'b0;
    {psel, penable, pwrite, flagsSet, retIrq} = 5'h00;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    srcEvent = 24'h00_0000;
    flagsVal = 8'h00;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      rd("posted reset", POS[k], 8'h00);
      rd("mask reset", MSK[k], 8'h00);
      apb(1'b1, MSK[k], 8'hFF);
      rd("mask bits", MSK[k], IMPL_MASK[8*k+:8]);
    end
    apb(1'b1, IDX_MASK1, 8'h00);
    rd("mask independent", IDX_MASK0, 8'hFD);
    apb(1'b1, IDX_MASK0, 8'h00);
    apb(1'b1, IDX_MASK2, 8'h00);
    ev(IMPL_MASK);
    for (int k = 0; k < 3; k++)
      rd("posted masked", POS[k], IMPL_MASK[8*k+:8]);
    rd("vector masked", IDX_VECTOR, 8'h00);
    apb(1'b1, IDX_MASK2, 8'h16);
    rd("vector unmask", IDX_VECTOR, 8'h44);
    apb(1'b1, IDX_POSTED2, 8'hFD);
    rd("vector clear", IDX_VECTOR, 8'h48);
    apb(1'b1, IDX_POSTED2, 8'hFF);
    rd("ones ignored", IDX_POSTED2, 8'h14);
    apb(1'b1, IDX_POSTED2, 8'hFB);
    rd("vector port2", IDX_VECTOR, 8'h50);
    apb(1'b1, IDX_MASK0, 8'h40);
    apb(1'b1, IDX_POSTED2, 8'h00);
    rd("vector sleep", IDX_VECTOR, 8'h64);
    apb(1'b1, IDX_POSTED0, 8'h00);
    apb(1'b1, IDX_POSTED1, 8'h00);
    apb(1'b1, IDX_SOFTPOST, 8'h80);
    rd("softpost", IDX_SOFTPOST, 8'h80);
    apb(1'b1, IDX_POSTED0, 8'h01);
    apb(1'b1, IDX_POSTED1, 8'h60);
    apb(1'b1, IDX_POSTED0, 8'h00);
    rd("soft post", IDX_POSTED0, 8'h01);
    apb(1'b1, IDX_MASK0, 8'h01);
    rd("vector soft", IDX_VECTOR, 8'h04);
    apb(1'b1, IDX_VECTOR, 8'h5A);
    rd("flush pending", IDX_POSTED0, 8'h00);
    rd("masked kept", IDX_POSTED1, 8'h60);
    apb(1'b1, IDX_SOFTPOST, 8'h00);
    apb(1'b1, IDX_POSTED1, 8'h00);
    apb(1'b0, 10'h000, 8'h00);
    chk("slverr", {31'h0, e}, 32'h0000_0001);
    srcEvent <= 24'h00_0010;
    apb(1'b1, IDX_POSTED0, 8'h00);
    srcEvent <= 24'h00_0000;
    rd("post beats clear", IDX_POSTED0, 8'h10);
    apb(1'b1, IDX_POSTED0, 8'h00);
    ev(24'h00_0005);
    apb(1'b1, IDX_MASK0, 8'h05);
    @(negedge core_clk);
    chk("no enable", {31'h0, irqRequest}, 32'h0000_0000);
    @(posedge core_clk);
    flagsVal <= 8'h05;
    flagsSet <= 1'b1;
    @(posedge core_clk);
    flagsSet <= 1'b0;
    wait (loadCnt == 1);
    while (dispatchBusy !== 1'b0) @(posedge core_clk);
    chk("push order", {8'h00, pushLog}, 32'h0012_3405);
    chk("vector pc", {16'h0000, programCounter}, 32'h0000_0004);
    chk("flags cleared", {24'h00_0000, cpuFlags}, 32'h0000_0000);
    chk("busy span", busyCnt, 32'h0000_000D);
    chk("held off", {31'h0, irqRequest}, 32'h0000_0000);
    rd("taken cleared", IDX_POSTED0, 8'h04);
    retIrq <= 1'b1;
    @(posedge core_clk);
    retIrq <= 1'b0;
    wait (loadCnt == 2);
    while (dispatchBusy !== 1'b0) @(posedge core_clk);
    chk("next pending", {16'h0000, programCounter}, 32'h0000_000C);
    chk("busy twice", busyCnt, 32'h0000_001A);
    end_sim();
  end
endmodule : irq_ctrl_tb
